/* logic/ppg_pkg.sv */
package ppg_pkg;
    localparam int unsigned WORD_W   = 64;
    localparam int unsigned LANES8   = 8;
    localparam int unsigned LANES16  = 4;
    localparam int unsigned LANES32  = 2;
    localparam int unsigned MASK_W   = 8;
    localparam logic [1:0]  SIZE_8   = 2'h0;
    localparam logic [1:0]  SIZE_16  = 2'h1;
    localparam logic [1:0]  SIZE_32  = 2'h2;
    localparam logic [1:0]  SIZE_BAD = 2'h3;
    localparam logic [63:0] WORD_RST = 64'h0000_0000_0000_0000;
    localparam logic [7:0]  MASK_RST = 8'h00;

    typedef enum logic [1:0] {
        PPG_OP_NONE,
        PPG_OP_ADD,
        PPG_OP_STORE
    } ppg_op_t;
endpackage

/* logic/ppg_lane_if.sv */
`timescale 1ns/1ps
interface ppg_lane_if;
    import ppg_pkg::*;
    logic [63:0] a;
    logic [63:0] b;
    logic [1:0]  size;
    logic [63:0] sum;
    logic [7:0]  lane_en;
    modport core  (output a, output b, output size, input sum, input lane_en);
    modport lanes (input a, input b, input size, output sum, output lane_en);
endinterface

/* logic/ppg_lane_adder.sv */
`timescale 1ns/1ps
module ppg_lane_adder
    import ppg_pkg::*;
(
    ppg_lane_if.lanes bus,
    input wire logic [7:0] pixel_update_mask
);
    // byte-lane carry chain, broken at every pixel boundary
    logic [8:0]  carry;
    logic [7:0]  cut;
    logic [63:0] sum_w;
    logic [7:0]  en8;
    logic [7:0]  en16;
    logic [7:0]  en32;

    assign carry[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_byte
            logic [8:0] part;
            // lane boundary every byte, every second byte, or every fourth byte
            assign cut[g] = (bus.size == SIZE_8)
                         || (bus.size == SIZE_16 && (g % 2) == 0)
                         || (bus.size == SIZE_32 && (g % 4) == 0);
            assign part = {1'b0, bus.a[g*8 +: 8]} + {1'b0, bus.b[g*8 +: 8]}
                        + {8'h00, (cut[g] ? 1'b0 : carry[g])};
            assign sum_w[g*8 +: 8] = part[7:0];
            assign carry[g+1] = part[8];
            assign en8[g]  = pixel_update_mask[g];
            assign en16[g] = pixel_update_mask[g/2];
            assign en32[g] = pixel_update_mask[g/4];
        end
    endgenerate

    assign bus.sum     = sum_w;
    assign bus.lane_en = (bus.size == SIZE_8)  ? en8 :
                         (bus.size == SIZE_16) ? en16 :
                         (bus.size == SIZE_32) ? en32 : 8'h00;
endmodule

/* logic/ppg_unit.sv */
`timescale 1ns/1ps
module ppg_unit
    import ppg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        op_valid,
    input  wire logic [1:0]  op_code,
    input  wire logic [1:0]  pixel_size_select,
    input  wire logic [7:0]  pixel_update_mask,
    input  wire logic [63:0] src_a,
    input  wire logic [63:0] src_b,
    output logic             res_valid,
    output logic [63:0]      res_data,
    output logic [7:0]       res_byte_we,
    output logic             res_size_bad
);
    ppg_lane_if lane_bus ();

    logic        is_add;
    logic        is_store;
    logic        size_bad;
    logic [63:0] store_word;
    logic [63:0] next_data;
    logic [7:0]  next_we;
    logic        valid_d;
    logic        valid_q;
    logic [63:0] data_d;
    logic [63:0] data_q;
    logic [7:0]  we_d;
    logic [7:0]  we_q;
    logic        bad_q;

    assign lane_bus.a    = src_a;
    assign lane_bus.b    = src_b;
    assign lane_bus.size = pixel_size_select;

    ppg_lane_adder u_lanes (
        .bus               (lane_bus.lanes),
        .pixel_update_mask (pixel_update_mask)
    );

    assign is_add   = op_valid && (op_code == PPG_OP_ADD);
    assign is_store = op_valid && (op_code == PPG_OP_STORE);
    assign size_bad = (pixel_size_select == SIZE_BAD);

    // merge: masked pixels from src_a, others keep old word in src_b
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_merge
            assign store_word[g*8 +: 8] = lane_bus.lane_en[g]
                                        ? src_a[g*8 +: 8] : src_b[g*8 +: 8];
        end
    endgenerate

    assign next_data = is_add ? lane_bus.sum : (is_store ? store_word : WORD_RST);
    assign next_we   = is_store ? lane_bus.lane_en : (is_add ? 8'hFF : MASK_RST);
    assign valid_d   = is_add || is_store;
    assign data_d    = next_data;
    assign we_d      = next_we;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            valid_q <= 1'b0;
            data_q  <= WORD_RST;
            we_q    <= MASK_RST;
            bad_q   <= 1'b0;
        end else begin
            valid_q <= valid_d;
            data_q  <= data_d;
            we_q    <= we_d;
            bad_q   <= valid_d && size_bad;
        end
    end

    assign res_valid    = valid_q;
    assign res_data     = data_q;
    assign res_byte_we  = we_q;
    assign res_size_bad = bad_q;

    // assertions
    property p_add8_no_carry;
        @(posedge core_clk) disable iff (rst)
        (is_add && pixel_size_select == SIZE_8)
            |=> res_data[15:8] == 8'($past(src_a[15:8]) + $past(src_b[15:8]));
    endproperty
    a_add8_no_carry: assert property (p_add8_no_carry) else $error("8-bit lane carried");

    property p_add16_lane;
        @(posedge core_clk) disable iff (rst)
        (is_add && pixel_size_select == SIZE_16)
            |=> res_data[31:16] == 16'($past(src_a[31:16]) + $past(src_b[31:16]));
    endproperty
    a_add16_lane: assert property (p_add16_lane) else $error("16-bit lane sum wrong");

    property p_add32_lane;
        @(posedge core_clk) disable iff (rst)
        (is_add && pixel_size_select == SIZE_32)
            |=> res_data[63:32] == 32'($past(src_a[63:32]) + $past(src_b[63:32]));
    endproperty
    a_add32_lane: assert property (p_add32_lane) else $error("32-bit lane sum wrong");

    property p_store8_we;
        @(posedge core_clk) disable iff (rst)
        (is_store && pixel_size_select == SIZE_8) |=> res_byte_we == $past(pixel_update_mask);
    endproperty
    a_store8_we: assert property (p_store8_we) else $error("8-bit store enables wrong");

    property p_store16_we;
        @(posedge core_clk) disable iff (rst)
        (is_store && pixel_size_select == SIZE_16)
            |=> res_byte_we[3:2] == {2{$past(pixel_update_mask[1])}};
    endproperty
    a_store16_we: assert property (p_store16_we) else $error("16-bit store enables wrong");

    property p_store_keep;
        @(posedge core_clk) disable iff (rst)
        (is_store && pixel_size_select == SIZE_32 && !pixel_update_mask[0])
            |=> res_data[31:0] == $past(src_b[31:0]);
    endproperty
    a_store_keep: assert property (p_store_keep) else $error("unmasked pixel changed");

    property p_store_hi_ignored;
        @(posedge core_clk) disable iff (rst)
        (is_store && pixel_size_select == SIZE_32 && pixel_update_mask[1:0] == 2'h0)
            |=> res_byte_we == 8'h00;
    endproperty
    a_store_hi_ignored: assert property (p_store_hi_ignored) else $error("unused mask bit used");

    property p_valid_follows;
        @(posedge core_clk) disable iff (rst)
        (op_valid && (op_code == PPG_OP_ADD || op_code == PPG_OP_STORE)) |=> res_valid;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("result valid misplaced");

    property p_bad_flag;
        @(posedge core_clk) disable iff (rst)
        (valid_d && size_bad) |=> res_size_bad;
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("illegal size not flagged");

    property p_idle_quiet;
        @(posedge core_clk) disable iff (rst)
        !(op_valid && (op_code == PPG_OP_ADD || op_code == PPG_OP_STORE))
            |=> !res_valid && res_data == WORD_RST && res_byte_we == MASK_RST;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle cycle gave a result");

    property p_add_we;
        @(posedge core_clk) disable iff (rst)
        is_add |=> res_byte_we == 8'hFF;
    endproperty
    a_add_we: assert property (p_add_we) else $error("add did not enable all bytes");

    property p_store32_we;
        @(posedge core_clk) disable iff (rst)
        (is_store && pixel_size_select == SIZE_32)
            |=> res_byte_we == {{4{$past(pixel_update_mask[1])}},
                                {4{$past(pixel_update_mask[0])}}};
    endproperty
    a_store32_we: assert property (p_store32_we) else $error("32-bit store enables wrong");

    property p_store16_all;
        @(posedge core_clk) disable iff (rst)
        (is_store && pixel_size_select == SIZE_16)
            |=> res_byte_we == {{2{$past(pixel_update_mask[3])}},
                                {2{$past(pixel_update_mask[2])}},
                                {2{$past(pixel_update_mask[1])}},
                                {2{$past(pixel_update_mask[0])}}};
    endproperty
    a_store16_all: assert property (p_store16_all) else $error("16-bit mask map wrong");

    property p_add_wide;
        @(posedge core_clk) disable iff (rst)
        (is_add && size_bad) |=> res_data == 64'($past(src_a) + $past(src_b));
    endproperty
    a_add_wide: assert property (p_add_wide) else $error("undefined size add wrong");

    property p_bad_quiet;
        @(posedge core_clk) disable iff (rst)
        (valid_d && !size_bad) |=> !res_size_bad;
    endproperty
    a_bad_quiet: assert property (p_bad_quiet) else $error("legal size flagged");

    property p_bad_store_we;
        @(posedge core_clk) disable iff (rst)
        (is_store && size_bad) |=> res_byte_we == MASK_RST;
    endproperty
    a_bad_store_we: assert property (p_bad_store_we) else $error("undefined size stored");

    // per-byte checks of sums and merges
    generate
        for (g = 0; g < 8; g++) begin : g_chk
            property p_byte_add8;
                @(posedge core_clk) disable iff (rst)
                (is_add && pixel_size_select == SIZE_8)
                    |=> res_data[g*8 +: 8]
                        == 8'($past(src_a[g*8 +: 8]) + $past(src_b[g*8 +: 8]));
            endproperty
            a_byte_add8: assert property (p_byte_add8) else $error("8-bit pixel sum wrong");

            property p_byte_store;
                @(posedge core_clk) disable iff (rst)
                is_store
                    |=> res_data[g*8 +: 8] == (res_byte_we[g] ? $past(src_a[g*8 +: 8])
                                                              : $past(src_b[g*8 +: 8]));
            endproperty
            a_byte_store: assert property (p_byte_store) else $error("stored byte wrong");
        end
    endgenerate

    c_add8:   cover property (@(posedge core_clk) is_add && pixel_size_select == SIZE_8);
    c_add16:  cover property (@(posedge core_clk) is_add && pixel_size_select == SIZE_16);
    c_store:  cover property (@(posedge core_clk) is_store && pixel_update_mask != 8'h00);
    c_b2b:    cover property (@(posedge core_clk) is_add ##1 is_store);
    c_wide:   cover property (@(posedge core_clk) is_add && size_bad);
endmodule

/* verif/ppg_core_drv.sv */
`timescale 1ns/1ps
module ppg_core_drv (
    input  wire logic        core_clk,
    output logic             op_valid,
    output logic [1:0]       op_code,
    output logic [1:0]       pixel_size_select,
    output logic [7:0]       pixel_update_mask,
    output logic [63:0]      src_a,
    output logic [63:0]      src_b
);
    initial begin
        op_valid = 1'b0;
        op_code = 2'h0;
        pixel_size_select = 2'h0;
        pixel_update_mask = 8'h00;
        src_a = 64'h0000_0000_0000_0000;
        src_b = 64'h0000_0000_0000_0000;
    end

    // put one request up at the next falling edge and leave it standing
    task automatic drive(input logic [1:0] op, input logic [1:0] sz, input logic [7:0] m,
                         input logic [63:0] a, input logic [63:0] b);
        @(negedge core_clk);
        op_valid <= 1'b1;
        op_code <= op;
        pixel_size_select <= sz;
        pixel_update_mask <= m;
        src_a <= a;
        src_b <= b;
    endtask

    // drop the request; operands scrambled so stale values cannot pass
    task automatic release_op;
        @(negedge core_clk);
        op_valid <= 1'b0;
        src_a <= ~src_a;
        src_b <= ~src_b;
        pixel_update_mask <= ~pixel_update_mask;
    endtask

    // one request, one cycle wide
    task automatic issue(input logic [1:0] op, input logic [1:0] sz, input logic [7:0] m,
                         input logic [63:0] a, input logic [63:0] b);
        drive(op, sz, m, a, b);
        release_op();
    endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    import ppg_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        op_valid, res_valid, res_size_bad;
    logic [1:0]  op_code, pixel_size_select;
    logic [7:0]  pixel_update_mask, res_byte_we;
    logic [63:0] src_a, src_b, res_data;
    int          failures = 0;
    int          n_checks = 0;

    always #2 core_clk = ~core_clk;

    ppg_core_drv ppg_core_drv_inst (.core_clk(core_clk), .op_valid(op_valid),
        .op_code(op_code), .pixel_size_select(pixel_size_select),
        .pixel_update_mask(pixel_update_mask), .src_a(src_a), .src_b(src_b));
    ppg_unit ppg_unit_inst (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .pixel_size_select(pixel_size_select),
        .pixel_update_mask(pixel_update_mask), .src_a(src_a), .src_b(src_b),
        .res_valid(res_valid), .res_data(res_data), .res_byte_we(res_byte_we),
        .res_size_bad(res_size_bad));

    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            failures++;
        end
    endtask

    // lane-cut ripple add; code 11 gives one 64-bit lane
    function automatic logic [63:0] exp_add(logic [63:0] a, logic [63:0] b, logic [1:0] sz);
        logic c;
        logic [63:0] r;
        int w;
        w = (sz == 2'h3) ? 64 : (8 << sz);
        c = 1'b0;
        for (int k = 0; k < 64; k++) begin
            if (k % w == 0) c = 1'b0;
            r[k] = a[k] ^ b[k] ^ c;
            c = (a[k] & b[k]) | (c & (a[k] ^ b[k]));
        end
        return r;
    endfunction

    function automatic logic [7:0] exp_we(logic [7:0] m, logic [1:0] sz);
        logic [7:0] we;
        for (int g = 0; g < 8; g++) we[g] = (sz == 2'h3) ? 1'b0 : m[g >> sz];
        return we;
    endfunction

    task automatic t_add;
        logic [63:0] a, b;
        a = 64'h80FF_7FFF_FFFF_00FF;
        b = 64'h8001_0001_0001_0001;
        for (int s = 0; s < 4; s++) begin
            ppg_core_drv_inst.issue(2'h1, s[1:0], 8'h00, a, b);
            chk("add valid", 64'h1, {63'h0, res_valid});
            chk("add data", exp_add(a, b, s[1:0]), res_data);
            chk("add we", 64'hFF, {56'h0, res_byte_we});
            chk("add bad", {63'h0, s == 3}, {63'h0, res_size_bad});
        end
    endtask

    task automatic t_store;
        logic [63:0] a, b, m;
        logic [7:0] we;
        a = 64'h1122_3344_5566_7788;
        b = 64'hA0B0_C0D0_E0F0_0A0B;
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 2; k++) begin
                we = exp_we(k ? 8'h5A : 8'hA5, s[1:0]);
                for (int g = 0; g < 8; g++) m[g*8 +: 8] = {8{we[g]}};
                ppg_core_drv_inst.issue(2'h2, s[1:0], k ? 8'h5A : 8'hA5, a, b);
                chk("st valid", 64'h1, {63'h0, res_valid});
                chk("st we", {56'h0, we}, {56'h0, res_byte_we});
                chk("st data", (a & m) | (b & ~m), res_data);
                chk("st bad", {63'h0, s == 3}, {63'h0, res_size_bad});
            end
        end
    endtask

    task automatic t_idle;
        for (int s = 0; s < 4; s += 3) begin
            ppg_core_drv_inst.issue(s[1:0], 2'h0, 8'hFF, 64'h1, 64'h1);
            chk("noop valid", 64'h0, {63'h0, res_valid});
            chk("noop data", 64'h0, res_data);
            chk("noop we", 64'h0, {56'h0, res_byte_we});
            chk("noop bad", 64'h0, {63'h0, res_size_bad});
        end
    endtask

    // reset raised mid-run over a taken request
    task automatic t_rst;
        rst = 1'b1;
        ppg_core_drv_inst.issue(2'h1, 2'h3, 8'hFF, 64'h1, 64'h1);
        chk("mid rst valid", 64'h0, {63'h0, res_valid});
        chk("mid rst data", 64'h0, res_data);
        chk("mid rst we", 64'h0, {56'h0, res_byte_we});
        chk("mid rst bad", 64'h0, {63'h0, res_size_bad});
        rst = 1'b0;
    endtask

    // add then store on consecutive edges
    task automatic t_b2b;
        logic [63:0] a, b, m;
        logic [7:0] we;
        a = 64'h00FF_00FF_7F80_FF01;
        b = 64'h0001_0001_0180_01FF;
        we = exp_we(8'h09, 2'h1);
        for (int g = 0; g < 8; g++) m[g*8 +: 8] = {8{we[g]}};
        ppg_core_drv_inst.drive(2'h1, 2'h0, 8'h00, a, b);
        ppg_core_drv_inst.drive(2'h2, 2'h1, 8'h09, a, b);
        chk("b2b add valid", 64'h1, {63'h0, res_valid});
        chk("b2b add data", exp_add(a, b, 2'h0), res_data);
        ppg_core_drv_inst.release_op();
        chk("b2b st valid", 64'h1, {63'h0, res_valid});
        chk("b2b st we", {56'h0, we}, {56'h0, res_byte_we});
        chk("b2b st data", (a & m) | (b & ~m), res_data);
    endtask

    initial begin
        #100000;
        failures++;
        close_out();
    end

    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        chk("rst valid", 64'h0, {63'h0, res_valid});
        chk("rst data", 64'h0, res_data);
        chk("rst we", 64'h0, {56'h0, res_byte_we});
        chk("rst bad", 64'h0, {63'h0, res_size_bad});
        t_add();
        t_store();
        t_idle();
        t_rst();
        t_b2b();
        close_out();
    end
endmodule
